// ### include/irv_pkg.sv
// Purpose: shared constants of the interrupt request and vectoring pair
// Assumes: one 200 MHz clock, asynchronous active-high reset
// Notes: device registers are 8 bits wide, reached by a 3-bit index
package irv_pkg;
  localparam int NGRP = 3;
  localparam int NTM = 3;
  localparam int NVEC = 4;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 8;
  // device register indices
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_SRCEN = 3'h1;
  localparam logic [2:0] REG_FLAGS = 3'h2;
  localparam logic [2:0] REG_TMFLG = 3'h3;
  // CTRL fields
  localparam int CTRL_GIE = 0;
  localparam int CTRL_CONV_EN = 1;
  localparam int CTRL_GRP_EN = 2;
  // SRCEN fields; timer enables sit as A0,P0,A1,P1,A2,P2
  localparam int SRCEN_NVM = 0;
  localparam int SRCEN_LV = 1;
  localparam int SRCEN_TMR = 2;
  // FLAGS fields
  localparam int FLG_CONV = 0;
  localparam int FLG_GRP = 1;
  localparam int FLG_NVM = 4;
  localparam int FLG_LV = 5;
  localparam logic [7:0] REG_RESET = 8'h00;
  // vector index: 0 converter, 1..3 groups; lower index means lower address
  localparam logic [1:0] VEC_CONV = 2'h0;
  localparam logic [PC_W-1:0] VEC_BASE = 12'h004;
  localparam logic [PC_W-1:0] VEC_STEP = 12'h004;
  // software register offsets of the sequencer end
  localparam logic [3:0] AXI_DEVDATA = 4'h0;
  localparam logic [3:0] AXI_DEVSEL = 4'h4;
  localparam logic [3:0] AXI_CMD = 4'h8;
  localparam logic [3:0] AXI_STATUS = 4'hC;
  localparam int CMD_RTN_EN = 0;
  localparam int CMD_RET = 1;
  localparam int CMD_SLEEP = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irv_pkg

// ### include/irv_if.sv
// Purpose: link between interrupt logic and the program sequencer
// Assumes: both ends on the same clock
// Notes: no clocking block; every signal is a registered output of its end
`timescale 1ns/1ps
interface irv_if;
  logic irq_req;
  logic [1:0] irq_vec;
  logic wake;
  logic [7:0] reg_rdata;
  logic stack_full;
  logic irq_ack;
  logic [1:0] ack_vec;
  logic ret_en;
  logic sleeping;
  logic reg_wr;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  modport dev (
    output irq_req, irq_vec, wake, reg_rdata,
    input stack_full, irq_ack, ack_vec, ret_en, sleeping, reg_wr, reg_addr, reg_wdata
  );
  modport core (
    input irq_req, irq_vec, wake, reg_rdata,
    output stack_full, irq_ack, ack_vec, ret_en, sleeping, reg_wr, reg_addr, reg_wdata
  );
endinterface : irv_if

// ### hw/irv_device.sv
// Purpose: request flags, enables, grouping, priority and wake-up
// Assumes: event inputs are one-cycle pulses on REF_CLK, except the pin and SUPPLY_LOW, which are levels
// Notes: flags stay set until written by software; service clears only converter and group flags
`timescale 1ns/1ps

// Notes on behaviour
// - conversion end sets converter flag
// - converter vectors when flagged, enabled, stack free
// - converter service clears its flag and global enable
// - three groups built from timer, nvm, voltage
// - group flag set when enabled member flag rises
// - group service clears group flag only
// - nvm write end sets its flag
// - nvm needs global, own, group enable
// - low voltage or low pin sets flag
// - each timer: A and P flags, enables
// - timer service clears group flag only
// - any flag rising wakes, enables ignored
// - voltage pin can flag while asleep
// - software presets flag to block wake
// - disabling blocks service, flag stays set
// - only program counter pushed on entry
// - enable-return sets global enable, plain not
// - avoid calls inside a service routine
// - vector needs enable and free stack
module irv_device (
  input wire logic REF_CLK, // system clock
  input wire logic RST, // asynchronous reset
  irv_if.dev LNK, // sequencer link
  input wire logic ADC_DONE, // conversion finished pulse
  input wire logic NVM_WRITE_END, // nonvolatile write cycle end pulse
  input wire logic SUPPLY_LOW, // detector reports low supply
  input wire logic VOLTAGE_DETECT_IN, // external detector pin
  input wire logic [2:0] TIMER_MATCH_A, // comparator A match pulses
  input wire logic [2:0] TIMER_MATCH_P, // comparator P match pulses
  output logic GLOBAL_EN, // global enable state
  output logic [3:0] PENDING // enabled requests waiting
);
  typedef struct packed {
    logic gie;
    logic conv_en;
    logic [2:0] grp_en;
    logic nvm_en;
    logic lv_en;
    logic [5:0] tmr_en;
    logic conv_f;
    logic [2:0] grp_f;
    logic nvm_f;
    logic lv_f;
    logic [5:0] tmr_f;
    logic [2:0] pin_sync;
    logic pin_lvl;
    logic lv_cond;
    logic req;
    logic [1:0] vec;
    logic wake;
    logic [3:0] pend;
    logic [7:0] rdata;
  } irv_dev_s;

  irv_dev_s q;
  irv_dev_s n;
  logic [5:0] tmr_ev;

  // interleave timer events as A0,P0,A1,P1,A2,P2
  for (genvar t = 0; t < irv_pkg::NTM; t++) begin : g_tmr
    assign tmr_ev[2*t] = TIMER_MATCH_A[t];
    assign tmr_ev[2*t+1] = TIMER_MATCH_P[t];
  end

  always_comb begin
    logic lv_now;
    logic [5:0] tmr_rise;
    logic nvm_rise;
    logic lv_rise;
    logic [12:0] f_old;
    logic [12:0] f_new;
    logic [3:0] pend;
    lv_now = 1'b0;
    tmr_rise = 6'h00;
    nvm_rise = 1'b0;
    lv_rise = 1'b0;
    f_old = 13'h0000;
    f_new = 13'h0000;
    pend = 4'h0;
    n = q;

    // three stages; only the second and third are compared
    n.pin_sync = {q.pin_sync[1:0], VOLTAGE_DETECT_IN};
    if (q.pin_sync[1] == q.pin_sync[2]) begin
      n.pin_lvl = q.pin_sync[2];
    end
    // the pin path is level based, so a low seen while asleep still flags
    lv_now = SUPPLY_LOW | ~q.pin_lvl;
    n.lv_cond = lv_now;

    // software access; flags may be written either way
    if (LNK.reg_wr) begin
      case (LNK.reg_addr)
        irv_pkg::REG_CTRL: begin
          n.gie = LNK.reg_wdata[irv_pkg::CTRL_GIE];
          n.conv_en = LNK.reg_wdata[irv_pkg::CTRL_CONV_EN];
          n.grp_en = LNK.reg_wdata[irv_pkg::CTRL_GRP_EN +: 3];
        end
        irv_pkg::REG_SRCEN: begin
          n.nvm_en = LNK.reg_wdata[irv_pkg::SRCEN_NVM];
          n.lv_en = LNK.reg_wdata[irv_pkg::SRCEN_LV];
          n.tmr_en = LNK.reg_wdata[irv_pkg::SRCEN_TMR +: 6];
        end
        irv_pkg::REG_FLAGS: begin
          n.conv_f = LNK.reg_wdata[irv_pkg::FLG_CONV];
          n.grp_f = LNK.reg_wdata[irv_pkg::FLG_GRP +: 3];
          n.nvm_f = LNK.reg_wdata[irv_pkg::FLG_NVM];
          n.lv_f = LNK.reg_wdata[irv_pkg::FLG_LV];
        end
        irv_pkg::REG_TMFLG: begin
          n.tmr_f = LNK.reg_wdata[5:0];
        end
        default: begin
        end
      endcase
    end

    // service: clear the serviced request and the global enable
    if (LNK.irq_ack) begin
      n.gie = 1'b0;
      if (LNK.ack_vec == irv_pkg::VEC_CONV) begin
        n.conv_f = 1'b0;
      end else begin
        // member source flags are left for software
        n.grp_f[LNK.ack_vec - 2'h1] = 1'b0;
      end
    end
    if (LNK.ret_en) begin
      n.gie = 1'b1;
    end

    // hardware events last, so a set beats a same-cycle clear
    if (ADC_DONE) begin
      n.conv_f = 1'b1;
    end
    if (NVM_WRITE_END) begin
      n.nvm_f = 1'b1;
    end
    if (lv_now && !q.lv_cond) begin
      n.lv_f = 1'b1;
    end
    n.tmr_f = n.tmr_f | tmr_ev;

    // a member reaches its group only while its own enable is set
    tmr_rise = n.tmr_f & ~q.tmr_f & q.tmr_en;
    nvm_rise = n.nvm_f & ~q.nvm_f & q.nvm_en;
    lv_rise = n.lv_f & ~q.lv_f & q.lv_en;
    if (|tmr_rise[3:0]) begin
      n.grp_f[0] = 1'b1;
    end
    if (|tmr_rise[5:4]) begin
      n.grp_f[1] = 1'b1;
    end
    if (nvm_rise || lv_rise) begin
      n.grp_f[2] = 1'b1;
    end

    // wake on any rising flag, enables play no part
    f_old = {q.conv_f, q.grp_f, q.nvm_f, q.lv_f, q.tmr_f, q.lv_cond};
    f_new = {n.conv_f, n.grp_f, n.nvm_f, n.lv_f, n.tmr_f, 1'b0};
    n.wake = |(f_new[12:1] & ~f_old[12:1]);

    // enable bits only gate service; flags are untouched here
    pend = {n.grp_f & n.grp_en, n.conv_f & n.conv_en};
    n.pend = pend;
    n.req = n.gie && !LNK.stack_full && (|pend);
    n.vec = q.vec;
    for (int i = irv_pkg::NVEC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        n.vec = 2'(i);
      end
    end

    case (LNK.reg_addr)
      irv_pkg::REG_CTRL: n.rdata = {3'h0, n.grp_en, n.conv_en, n.gie};
      irv_pkg::REG_SRCEN: n.rdata = {n.tmr_en, n.lv_en, n.nvm_en};
      irv_pkg::REG_FLAGS: n.rdata = {2'h0, n.lv_f, n.nvm_f, n.grp_f, n.conv_f};
      irv_pkg::REG_TMFLG: n.rdata = {2'h0, n.tmr_f};
      default: n.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
      q.pin_sync <= 3'h7;
      q.pin_lvl <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // program counter save happens at the far end; nothing else is kept
  assign LNK.irq_req = q.req;
  assign LNK.irq_vec = q.vec;
  assign LNK.wake = q.wake;
  assign LNK.reg_rdata = q.rdata;
  assign GLOBAL_EN = q.gie;
  assign PENDING = q.pend;
endmodule : irv_device

// ### hw/irv_core.sv
// Purpose: sequencer end: return stack, vector calls, returns, sleep
// Assumes: software drives it over AXI4-Lite with 32-bit data
// Notes: a request is taken at most once per acknowledge turn-around
`timescale 1ns/1ps
module irv_core (
  input wire logic REF_CLK, // system clock
  input wire logic RST, // asynchronous reset
  irv_if.core LNK, // interrupt logic link
  input wire logic [11:0] PC_IN, // address of next instruction
  output logic [11:0] PC_OUT, // new program counter
  output logic PC_LOAD, // load PC_OUT, one cycle
  output logic SLEEPING, // low-power state
  input wire logic [3:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [3:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY // read data ready
);
  typedef enum logic {PH_RUN, PH_SLEEP} irv_phase_e;
  typedef struct packed {
    irv_phase_e ph;
    logic aw_ok;
    logic [3:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] sel;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic irq_ack;
    logic [1:0] ack_vec;
    logic ret_en;
    logic [3:0] depth;
    logic full;
    logic [7:0][11:0] stack;
    logic [11:0] pc;
    logic pc_load;
  } irv_core_s;

  irv_core_s q;
  irv_core_s n;

  always_comb begin
    logic do_ret;
    logic do_rtn_en;
    logic do_sleep;
    do_ret = 1'b0;
    do_rtn_en = 1'b0;
    do_sleep = 1'b0;
    n = q;
    n.reg_wr = 1'b0;
    n.irq_ack = 1'b0;
    n.ret_en = 1'b0;
    n.pc_load = 1'b0;

    if (S_AXI_AWVALID && q.awready) begin
      n.aw_ok = 1'b1;
      n.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.wready) begin
      n.w_ok = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_ok && n.w_ok && !n.bvalid) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = irv_pkg::RESP_OKAY;
      case (n.aw_addr)
        irv_pkg::AXI_DEVDATA: begin
          n.reg_wr = n.wstrb[0];
          n.reg_wdata = n.wdata[7:0];
        end
        irv_pkg::AXI_DEVSEL: begin
          if (n.wstrb[0]) n.sel = n.wdata[2:0];
        end
        irv_pkg::AXI_CMD: begin
          do_rtn_en = n.wstrb[0] & n.wdata[irv_pkg::CMD_RTN_EN];
          do_ret = n.wstrb[0] & n.wdata[irv_pkg::CMD_RET];
          do_sleep = n.wstrb[0] & n.wdata[irv_pkg::CMD_SLEEP];
        end
        irv_pkg::AXI_STATUS: begin
        end
        default: n.bresp = irv_pkg::RESP_SLVERR;
      endcase
    end

    if (S_AXI_RVALID && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = irv_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        irv_pkg::AXI_DEVDATA: n.rdata = {24'h00_0000, LNK.reg_rdata};
        irv_pkg::AXI_DEVSEL: n.rdata = {29'h0000_0000, q.sel};
        irv_pkg::AXI_CMD: n.rdata = 32'h0000_0000;
        irv_pkg::AXI_STATUS: n.rdata = {24'h00_0000, q.ack_vec, q.ph == PH_SLEEP,
                                        q.full, q.depth};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = irv_pkg::RESP_SLVERR;
        end
      endcase
    end

    case (q.ph)
      PH_RUN: if (do_sleep) n.ph = PH_SLEEP;
      PH_SLEEP: if (LNK.wake) n.ph = PH_RUN;
      default: n.ph = PH_RUN;
    endcase

    // the acknowledge cycle masks the request still on the link
    if (LNK.irq_req && !q.irq_ack && !q.full) begin
      // only the program counter is saved
      n.stack[q.depth[2:0]] = PC_IN;
      n.depth = q.depth + 4'h1;
      n.pc = irv_pkg::VEC_BASE + irv_pkg::VEC_STEP * {10'h000, LNK.irq_vec};
      n.pc_load = 1'b1;
      n.irq_ack = 1'b1;
      n.ack_vec = LNK.irq_vec;
      n.ph = PH_RUN;
    end else if ((do_ret || do_rtn_en) && q.depth != 4'h0) begin
      n.depth = q.depth - 4'h1;
      n.pc = q.stack[n.depth[2:0]];
      n.pc_load = 1'b1;
      n.ret_en = do_rtn_en;
    end
    n.full = (n.depth == 4'(irv_pkg::STACK_DEPTH));
    n.awready = !n.aw_ok && !n.bvalid;
    n.wready = !n.w_ok && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign LNK.stack_full = q.full;
  assign LNK.irq_ack = q.irq_ack;
  assign LNK.ack_vec = q.ack_vec;
  assign LNK.ret_en = q.ret_en;
  assign LNK.sleeping = q.ph == PH_SLEEP;
  assign LNK.reg_wr = q.reg_wr;
  assign LNK.reg_addr = q.sel;
  assign LNK.reg_wdata = q.reg_wdata;
  assign PC_OUT = q.pc;
  assign PC_LOAD = q.pc_load;
  assign SLEEPING = q.ph == PH_SLEEP;
  assign S_AXI_AWREADY = q.awready;
  assign S_AXI_WREADY = q.wready;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_ARREADY = q.arready;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign S_AXI_RVALID = q.rvalid;
endmodule : irv_core

// ### verif/irv_sva.sv
// Purpose: temporal checks on the interrupt link
// Assumes: one clock, reset asynchronous and active high
// Notes: watches link signals and the device status outputs
`timescale 1ns/1ps
module irv_sva (
  input wire logic REF_CLK, // clock
  input wire logic RST, // reset
  input wire logic irq_req, // request
  input wire logic [1:0] irq_vec, // request index
  input wire logic wake, // wake pulse
  input wire logic stack_full, // stack full
  input wire logic irq_ack, // acknowledge
  input wire logic [1:0] ack_vec, // taken index
  input wire logic ret_en, // enabling return
  input wire logic sleeping, // low power
  input wire logic GLOBAL_EN, // global enable
  input wire logic [3:0] PENDING // enabled requests
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_ack_needs_req: assert property ($rose(irq_ack) |-> $past(irq_req) && !$past(stack_full))
    else $error("acknowledge without free request");
  chk_ack_vec_match: assert property (irq_ack |-> ack_vec == $past(irq_vec))
    else $error("acknowledged index differs");
  chk_ack_clears_en: assert property (irq_ack |=> !GLOBAL_EN && !irq_req)
    else $error("service left enable set");
  chk_ack_one_pulse: assert property (irq_ack |=> !irq_ack)
    else $error("acknowledge longer than one cycle");
  chk_req_needs_en: assert property (irq_req |-> GLOBAL_EN && PENDING != 4'h0)
    else $error("request while disabled");
  chk_vec_priority: assert property (irq_req |-> PENDING[irq_vec] &&
    ((PENDING & ((4'h1 << irq_vec) - 4'h1)) == 4'h0))
    else $error("request index not lowest");
  chk_return_with_enable_sets_en: assert property (ret_en |=> GLOBAL_EN)
    else $error("enabling return left enable clear");
  chk_wake_exits: assert property (wake && sleeping |=> !sleeping)
    else $error("wake did not end sleep");
  cover property (irq_ack && ack_vec == 2'h0);
  cover property (irq_ack && ack_vec == 2'h3);
  cover property (wake && sleeping);
endmodule : irv_sva

// ### verif/tb_interrupt_request_vectoring.sv
// Purpose: drives both ends joined by the link and judges results
// Assumes: software reaches the core over AXI4-Lite
// Notes: loads counts program counter loads so none is missed mid-bus
`timescale 1ns/1ps
module tb_interrupt_request_vectoring;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic adc = 1'b0, nvm = 1'b0, sup_low = 1'b0, pin = 1'b1;
  logic [2:0] tma = 3'h0, tmp = 3'h0;
  logic [11:0] pc_in = 12'h3a0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wr, bv, arr, rv, glb, pcl, slp;
  logic [1:0] br, rr, resp;
  logic [31:0] rdt, rd;
  logic [3:0] pend;
  logic [11:0] pco, lastpc = 12'h000;
  int loads = 0, miscompares = 0, n_checks = 0;
  irv_if lnk ();
  irv_device irv_device_i (.REF_CLK(clk), .RST(rst), .LNK(lnk), .ADC_DONE(adc),
    .NVM_WRITE_END(nvm), .SUPPLY_LOW(sup_low), .VOLTAGE_DETECT_IN(pin),
    .TIMER_MATCH_A(tma), .TIMER_MATCH_P(tmp), .GLOBAL_EN(glb), .PENDING(pend));
  irv_core irv_core_i (.REF_CLK(clk), .RST(rst), .LNK(lnk), .PC_IN(pc_in), .PC_OUT(pco),
    .PC_LOAD(pcl), .SLEEPING(slp), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
  irv_sva irv_sva_i (.REF_CLK(clk), .RST(rst), .irq_req(lnk.irq_req), .irq_vec(lnk.irq_vec),
    .wake(lnk.wake), .stack_full(lnk.stack_full), .irq_ack(lnk.irq_ack),
    .ack_vec(lnk.ack_vec), .ret_en(lnk.ret_en), .sleeping(lnk.sleeping),
    .GLOBAL_EN(glb), .PENDING(pend));
  always #2.5 clk = ~clk;
  // a load may land while a bus cycle is still open, so record it here
  always @(posedge clk) begin
    if (pcl === 1'b1) begin
      loads <= loads + 1;
      lastpc <= pco;
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask : chk
  task axw(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      ta = ta | awr;
      tw = tw | wr;
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    do @(posedge clk); while (bv !== 1'b1);
    resp = br;
  endtask : axw
  task axr(input logic [3:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rd = rdt;
    resp = rr;
    rry <= 1'b0;
  endtask : axr
  task dw(input logic [2:0] i, input logic [7:0] v);
    axw(irv_pkg::AXI_DEVSEL, {29'h0000_0000, i});
    axw(irv_pkg::AXI_DEVDATA, {24'h00_0000, v});
  endtask : dw
  task dr(input logic [2:0] i);
    axw(irv_pkg::AXI_DEVSEL, {29'h0000_0000, i});
    repeat (2) @(posedge clk);
    axr(irv_pkg::AXI_DEVDATA);
  endtask : dr
  task cmd(input int b);
    axw(irv_pkg::AXI_CMD, 32'h0000_0001 << b);
  endtask : cmd
  task wl(input int n);
    for (int k = 0; k < 60 && loads != n; k++) @(posedge clk);
    chk(32'(loads), 32'(n));
  endtask : wl
  task wk(input logic e);
    for (int k = 0; k < 20 && slp === 1'b1; k++) @(posedge clk);
    chk(slp, e);
  endtask : wk
  task zz;
    cmd(irv_pkg::CMD_SLEEP);
    repeat (3) @(posedge clk);
    chk(slp, 1'b1);
  endtask : zz
  task t_conv;
    dw(irv_pkg::REG_CTRL, 8'h03);
    adc <= 1'b1;
    @(posedge clk);
    adc <= 1'b0;
    wl(1);
    chk(lastpc, irv_pkg::VEC_BASE);
    chk(glb, 1'b0);
    axr(irv_pkg::AXI_STATUS);
    chk(rd[7:0], 8'h01);
    dr(irv_pkg::REG_FLAGS);
    chk(rd[0], 1'b0);
    cmd(irv_pkg::CMD_RTN_EN);
    wl(2);
    chk(lastpc, 12'h3a0);
    chk(glb, 1'b1);
  endtask : t_conv
  task t_grp;
    dw(irv_pkg::REG_SRCEN, 8'h01);
    dw(irv_pkg::REG_CTRL, 8'h11);
    nvm <= 1'b1;
    @(posedge clk);
    nvm <= 1'b0;
    wl(3);
    chk(lastpc, irv_pkg::VEC_BASE + irv_pkg::VEC_STEP * 12'h003);
    dr(irv_pkg::REG_FLAGS);
    chk(rd[7:0], 8'h10);
    cmd(irv_pkg::CMD_RET);
    wl(4);
    chk(glb, 1'b0);
    dw(irv_pkg::REG_FLAGS, 8'h00);
  endtask : t_grp
  task t_prio;
    dw(irv_pkg::REG_SRCEN, 8'h04);
    dw(irv_pkg::REG_CTRL, 8'h06);
    adc <= 1'b1;
    tma <= 3'h1;
    @(posedge clk);
    adc <= 1'b0;
    tma <= 3'h0;
    repeat (4) @(posedge clk);
    chk(pend, 4'h3);
    dw(irv_pkg::REG_CTRL, 8'h07);
    wl(5);
    chk(lastpc, irv_pkg::VEC_BASE);
    cmd(irv_pkg::CMD_RTN_EN);
    wl(7);
    chk(lastpc, irv_pkg::VEC_BASE + irv_pkg::VEC_STEP);
    dr(irv_pkg::REG_TMFLG);
    chk(rd[0], 1'b1);
    cmd(irv_pkg::CMD_RTN_EN);
    wl(8);
    dw(irv_pkg::REG_TMFLG, 8'h00);
    dw(irv_pkg::REG_CTRL, 8'h00);
  endtask : t_prio
  task t_wake;
    axw(4'h2, 32'h0000_0000);
    chk(resp, irv_pkg::RESP_SLVERR);
    axr(4'h2);
    chk(resp, irv_pkg::RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    zz;
    chk(slp, 1'b1);
    tmp <= 3'h4;
    @(posedge clk);
    tmp <= 3'h0;
    wk(1'b0);
    zz;
    pin <= 1'b0;
    wk(1'b0);
    dr(irv_pkg::REG_FLAGS);
    chk(rd[5], 1'b1);
    dw(irv_pkg::REG_FLAGS, 8'h01);
    pin <= 1'b1;
    zz;
    adc <= 1'b1;
    @(posedge clk);
    adc <= 1'b0;
    wk(1'b1);
    sup_low <= 1'b1;
    wk(1'b0);
  endtask : t_wake
  initial begin
    #200000;
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_conv;
    t_grp;
    t_prio;
    t_wake;
    give_verdict;
  end
endmodule : tb_interrupt_request_vectoring
